// file: core/apc_pkg.sv
// apc_pkg: constants and carriers for the audio port clock block
// assumes a 25 MHz reference clock and 8-bit register access
package apc_pkg;
    localparam longint CLK_HZ = 25_000_000;
    // register offsets
    localparam logic [7:0] MODE_CFG_OFS = 8'h13;
    localparam logic [7:0] RATE_CFG_OFS = 8'h14;
    localparam logic [7:0] MON_STS_OFS = 8'h15;
    localparam logic [7:0] CLK_SRC_OFS = 8'h16;
    // reset values
    localparam logic [7:0] MODE_CFG_RST = 8'h02;
    localparam logic [7:0] RATE_CFG_RST = 8'h48;
    localparam logic [7:0] MON_STS_RST = 8'hFF;
    localparam logic CLK_SRC_STYLE_RST = 1'b0;
    localparam int CLK_SRC_STYLE_BIT = 6;
    // codes
    localparam logic [3:0] STS_INVALID = 4'hF;
    localparam logic [3:0] RATE_CODE_MAX = 4'h8;
    localparam logic [3:0] RATIO_CODE_MAX = 4'hC;
    localparam logic [3:0] RATE_FALLBACK = 4'h4;
    localparam logic [3:0] RATIO_FALLBACK = 4'h8;
    // bit clocks per frame, codes 0 to 12
    localparam int RATIO_TBL [13] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024,
        2048};
    // frame rates in Hz, codes 0 to 8, each family
    localparam int RATE48_HZ [9] = '{8000, 16000, 24000, 32000, 48000, 96000, 192000, 384000,
        768000};
    localparam int RATE44_HZ [9] = '{7350, 14700, 22050, 29400, 44100, 88200, 176400, 352800,
        705600};
    // measurement tolerance in 32nds and silence timeout in reference cycles
    localparam int TOL_LO_32 = 31;
    localparam int TOL_HI_32 = 33;
    localparam logic [11:0] MON_TIMEOUT = 12'hFFF;

    typedef struct packed {
        logic drive_clocks_select;
        logic auto_clk_off;
        logic auto_loop_off;
        logic port_clock_gate;
        logic rate_family_select;
        logic [2:0] master_clock_freq_code;
    } apc_mode_cfg_t;

    typedef struct packed {
        logic [3:0] programmed_rate_code;
        logic [3:0] programmed_ratio_code;
    } apc_rate_cfg_t;

    typedef struct packed {
        logic [3:0] detected_rate_code;
        logic [3:0] detected_ratio_code;
    } apc_mon_sts_t;
endpackage : apc_pkg

// file: core/apc_top.sv
// apc_top: audio serial port clock drive, gating and bus clock monitor
// assumes a register port on the reference clock; pins pass a 3-flop synchroniser
//
// Functional notes
// - select bit 0 receives clocks, 1 drives them
// - auto bit 0 derives dividers and PLL automatically
// - auto mode: PLL runs unless loop-off set
// - master gate bit holds outgoing clocks low
// - family bit picks 48 kHz or 44.1 kHz
// - 3-bit code names master clock frequency
// - rate field, reset 4, unused slave auto
// - ratio field sets bit clocks per frame
// - detected rate reported, 15 when invalid
// - detected ratio reported, 15 when invalid
// - style bit picks code or frame multiple
`timescale 1ns/1ps
module apc_top
    import apc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic bclk_in,
    input wire logic frame_sync_in,
    output logic [7:0] reg_rdata_out,
    output logic bclk_out,
    output logic bclk_oe_n_out,
    output logic frame_sync_out,
    output logic frame_sync_oe_n_out,
    output logic pll_run_out,
    output logic custom_clk_out,
    output logic mclk_from_code_out,
    output logic [2:0] master_clock_freq_code_out
);
    typedef logic [7:0] apc_div_tbl_t [0:511];

    // half bit-clock period in reference cycles for {family, rate, ratio}
    function automatic apc_div_tbl_t build_div_tbl();
        apc_div_tbl_t t;
        longint hz;
        longint h;
        int r;
        int q;
        for (int i = 0; i < 512; i++) begin
            r = ((i >> 4) & 15) > 8 ? 4 : ((i >> 4) & 15);
            q = (i & 15) > 12 ? 8 : (i & 15);
            hz = (i >= 256) ? RATE44_HZ[r] : RATE48_HZ[r];
            h = CLK_HZ / (2 * hz * RATIO_TBL[q]);
            t[i] = (h < 1) ? 8'h01 : ((h > 255) ? 8'hFF : 8'(h));
        end
        return t;
    endfunction : build_div_tbl

    localparam apc_div_tbl_t DIV_TBL = build_div_tbl();

    // frame period in reference cycles to rate code
    function automatic logic [3:0] classify_rate(input logic [11:0] per);
        logic [3:0] c;
        c = STS_INVALID;
        for (int k = 0; k < 9; k++) begin
            if (longint'(per) >= CLK_HZ / RATE48_HZ[k] * TOL_LO_32 / 32 &&
                longint'(per) <= CLK_HZ / RATE44_HZ[k] * TOL_HI_32 / 32) begin
                c = 4'(k);
            end
        end
        return c;
    endfunction : classify_rate

    // bit clocks per frame to ratio code
    function automatic logic [3:0] classify_ratio(input logic [11:0] bits);
        logic [3:0] c;
        c = STS_INVALID;
        for (int k = 0; k < 13; k++) begin
            if (32'(bits) == RATIO_TBL[k]) begin
                c = 4'(k);
            end
        end
        return c;
    endfunction : classify_ratio

    apc_mode_cfg_t mode_r;
    apc_rate_cfg_t rate_r;
    apc_mon_sts_t sts_r;
    logic style_r;
    logic [2:0] bclk_sy_r;
    logic [2:0] fs_sy_r;
    logic bclk_st_r;
    logic fs_st_r;
    logic [7:0] div_cnt_r;
    logic [11:0] bit_cnt_r;
    logic mon_b_prev_r;
    logic mon_f_prev_r;
    logic [11:0] per_cnt_r;
    logic [11:0] mon_bits_r;
    logic run;
    logic [7:0] half_div;
    logic [11:0] frame_bits;
    logic [3:0] rate_eff;
    logic [3:0] ratio_eff;
    logic mon_b;
    logic mon_f;
    logic rise_b;
    logic rise_f;

    // register writes; status is read-only and ignores writes
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_r <= MODE_CFG_RST;
            rate_r <= RATE_CFG_RST;
            style_r <= CLK_SRC_STYLE_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                MODE_CFG_OFS: mode_r <= reg_wdata_in;
                RATE_CFG_OFS: rate_r <= reg_wdata_in;
                CLK_SRC_OFS: style_r <= reg_wdata_in[CLK_SRC_STYLE_BIT];
                default: ;
            endcase
        end
    end

    // read data one cycle after the address; unmapped reads give zero
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            case (reg_addr_in)
                MODE_CFG_OFS: reg_rdata_out <= mode_r;
                RATE_CFG_OFS: reg_rdata_out <= rate_r;
                MON_STS_OFS: reg_rdata_out <= sts_r;
                CLK_SRC_OFS: reg_rdata_out <= 8'({style_r, 6'h00});
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // clock-tree controls towards the PLL and dividers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            custom_clk_out <= 1'b0;
            pll_run_out <= 1'b1;
            mclk_from_code_out <= 1'b1;
            master_clock_freq_code_out <= MODE_CFG_RST[2:0];
        end else begin
            custom_clk_out <= mode_r.auto_clk_off;
            // custom mode leaves the loop to outside settings, so held off here
            pll_run_out <= !mode_r.auto_clk_off && !mode_r.auto_loop_off;
            mclk_from_code_out <= !style_r;
            master_clock_freq_code_out <= mode_r.master_clock_freq_code;
        end
    end

    // reserved codes fall back to reset values rather than odd dividers
    always_comb begin
        rate_eff = (rate_r.programmed_rate_code > RATE_CODE_MAX) ? RATE_FALLBACK
                 : rate_r.programmed_rate_code;
        ratio_eff = (rate_r.programmed_ratio_code > RATIO_CODE_MAX) ? RATIO_FALLBACK
                  : rate_r.programmed_ratio_code;
        half_div = DIV_TBL[{mode_r.rate_family_select, rate_eff, ratio_eff}];
        frame_bits = 12'(RATIO_TBL[ratio_eff]);
    end

    // rate field only matters while driving, so slave auto ignores it
    assign run = mode_r.drive_clocks_select && !mode_r.port_clock_gate;

    // pin direction: enables low while driving
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bclk_oe_n_out <= 1'b1;
            frame_sync_oe_n_out <= 1'b1;
        end else begin
            bclk_oe_n_out <= !mode_r.drive_clocks_select;
            frame_sync_oe_n_out <= !mode_r.drive_clocks_select;
        end
    end

    // clock generator; frame sync changes on the falling bit clock
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_r <= 8'h00;
            bclk_out <= 1'b0;
            bit_cnt_r <= 12'h000;
            frame_sync_out <= 1'b0;
        end else if (!run) begin
            div_cnt_r <= 8'h00;
            bclk_out <= 1'b0;
            bit_cnt_r <= 12'h000;
            frame_sync_out <= 1'b0;
        end else if (div_cnt_r >= half_div - 8'h01) begin
            div_cnt_r <= 8'h00;
            bclk_out <= !bclk_out;
            if (bclk_out) begin
                bit_cnt_r <= (bit_cnt_r >= frame_bits - 12'h001) ? 12'h000
                           : bit_cnt_r + 12'h001;
                frame_sync_out <= (bit_cnt_r >= frame_bits - 12'h001);
            end
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bclk_sy_r <= 3'h0;
            fs_sy_r <= 3'h0;
            bclk_st_r <= 1'b0;
            fs_st_r <= 1'b0;
        end else begin
            bclk_sy_r <= {bclk_sy_r[1:0], bclk_in};
            fs_sy_r <= {fs_sy_r[1:0], frame_sync_in};
            if (bclk_sy_r[1] == bclk_sy_r[2]) begin
                bclk_st_r <= bclk_sy_r[2];
            end
            if (fs_sy_r[1] == fs_sy_r[2]) begin
                fs_st_r <= fs_sy_r[2];
            end
        end
    end

    // monitor watches whatever clocks are on the bus
    assign mon_b = mode_r.drive_clocks_select ? bclk_out : bclk_st_r;
    assign mon_f = mode_r.drive_clocks_select ? frame_sync_out : fs_st_r;
    assign rise_b = mon_b && !mon_b_prev_r;
    assign rise_f = mon_f && !mon_f_prev_r;

    // measure every frame; silence past the timeout marks both invalid
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mon_b_prev_r <= 1'b0;
            mon_f_prev_r <= 1'b0;
            per_cnt_r <= 12'h000;
            mon_bits_r <= 12'h000;
            sts_r <= MON_STS_RST;
        end else begin
            mon_b_prev_r <= mon_b;
            mon_f_prev_r <= mon_f;
            if (rise_f) begin
                sts_r.detected_rate_code <= classify_rate(per_cnt_r + 12'h001);
                sts_r.detected_ratio_code <= classify_ratio(mon_bits_r);
                per_cnt_r <= 12'h000;
                mon_bits_r <= {11'h000, rise_b};
            end else begin
                if (per_cnt_r == MON_TIMEOUT) begin
                    sts_r <= MON_STS_RST;
                end else begin
                    per_cnt_r <= per_cnt_r + 12'h001;
                end
                if (rise_b && mon_bits_r != 12'hFFF) begin
                    mon_bits_r <= mon_bits_r + 12'h001;
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_slave_held;
        !mode_r.drive_clocks_select ##1 !mode_r.drive_clocks_select;
    endsequence
    sequence s_gate_held;
        (mode_r.port_clock_gate)[*2];
    endsequence

    a_slave_pins_off: assert property (s_slave_held |-> bclk_oe_n_out && frame_sync_oe_n_out)
        else $error("pins driven in slave mode");
    a_gate_clocks_low: assert property (s_gate_held |-> !bclk_out && !frame_sync_out)
        else $error("clocks toggle while gated");
    a_auto_flag_out: assert property ($past(mode_r.auto_clk_off) |-> custom_clk_out)
        else $error("custom flag not following auto bit");
    a_pll_run_state: assert property (
        !mode_r.auto_clk_off && !mode_r.auto_loop_off |=> pll_run_out)
        else $error("pll not running in auto mode");
    a_pll_held_off: assert property (
        mode_r.auto_clk_off || mode_r.auto_loop_off |=> !pll_run_out)
        else $error("pll running while disabled");
    a_style_select: assert property (style_r ##1 style_r |-> !mclk_from_code_out)
        else $error("style select not applied");
    a_rate_no_reserved: assert property (!(sts_r.detected_rate_code inside {[9:14]}))
        else $error("reserved rate code reported");
    a_ratio_no_reserved: assert property (!(sts_r.detected_ratio_code inside {[13:14]}))
        else $error("reserved ratio code reported");
    a_silence_invalid: assert property (
        per_cnt_r == MON_TIMEOUT && !rise_f |-> ##1 sts_r == MON_STS_RST)
        else $error("silent bus not flagged invalid");
    a_bclk_toggles: assert property (
        run && $changed(bclk_out) ##1 run |-> ##[0:260] ($changed(bclk_out) || !run))
        else $error("bit clock stalled while driving");
endmodule : apc_top

// file: verif/apc_host_model.sv
// apc_host_model: host processor driving bit clock and frame sync in slave mode
// assumes the bench leaves run_in on across scenarios and turns it off at the end; clocks then stand still
`timescale 1ns/1ps
module apc_host_model (
    input wire logic run_in,
    input wire logic [31:0] frame_ns_in,
    input wire logic [11:0] ratio_in,
    output logic bclk_out,
    output logic frame_sync_out
);
    realtime half;

    // whole frames when run_in drops; ratio_in is read on each bit, so changing it mid-frame can cut a frame short
    initial begin
        bclk_out = 1'b0;
        frame_sync_out = 1'b0;
        forever begin
            wait (run_in);
            half = frame_ns_in / (2.0 * ratio_in);
            for (int i = 0; i < ratio_in; i++) begin
                frame_sync_out = (i == 0); // marker on the first bit of a frame
                #(half) bclk_out = 1'b1;
                #(half) bclk_out = 1'b0;
            end
            frame_sync_out = 1'b0;
        end
    end
endmodule : apc_host_model

// file: verif/apc_top_tb.sv
// apc_top_tb: register-level tests of the port clock block with a host model
// assumes 25 MHz reference; inputs change on the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module apc_top_tb;
    import apc_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic bclk_out, bclk_oe_n_out, frame_sync_out, frame_sync_oe_n_out;
    logic pll_run_out, custom_clk_out, mclk_from_code_out;
    logic [2:0] master_clock_freq_code_out;
    logic host_run = 1'b0;
    logic [31:0] host_frame_ns = 32'h0;
    logic [11:0] host_ratio = 12'h0;
    logic host_bclk, host_fs, bclk_wire, fs_wire;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] rd;
    int n;

    always #20 ref_clk_in = ~ref_clk_in;
    // wire level: the device drives while its enable is low
    assign bclk_wire = bclk_oe_n_out ? host_bclk : bclk_out;
    assign fs_wire = frame_sync_oe_n_out ? host_fs : frame_sync_out;

    apc_top apc_top_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .bclk_in(bclk_wire),
        .frame_sync_in(fs_wire), .reg_rdata_out(reg_rdata_out), .bclk_out(bclk_out),
        .bclk_oe_n_out(bclk_oe_n_out), .frame_sync_out(frame_sync_out),
        .frame_sync_oe_n_out(frame_sync_oe_n_out), .pll_run_out(pll_run_out),
        .custom_clk_out(custom_clk_out), .mclk_from_code_out(mclk_from_code_out),
        .master_clock_freq_code_out(master_clock_freq_code_out));
    apc_host_model apc_host_model_i (.run_in(host_run), .frame_ns_in(host_frame_ns),
        .ratio_in(host_ratio), .bclk_out(host_bclk), .frame_sync_out(host_fs));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // hang guard well above the longest expected run
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge ref_clk_in);
        reg_wr_in = 1'b0;
        @(negedge ref_clk_in);
    endtask : wr

    // answer one edge after the address, looked at on the next falling edge
    task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
        reg_addr_in = a;
        @(negedge ref_clk_in);
        d = reg_rdata_out;
    endtask : rdreg

    // poll status until it matches, bounded by lim reads
    task automatic wait_sts(input logic [7:0] e, input int lim);
        for (int i = 0; i < lim; i++) begin
            rdreg(MON_STS_OFS, rd);
            if (rd === e) break;
        end
    endtask : wait_sts

    task automatic count_rises(output int c);
        logic prev;
        c = 0;
        for (int i = 0; i < 200; i++) begin
            prev = bclk_out;
            @(negedge ref_clk_in);
            if (!prev && bclk_out === 1'b1) c++;
        end
    endtask : count_rises

    // length of one high phase of the generated bit clock, in reference cycles
    task automatic half_len(output int c);
        c = 0;
        while (bclk_out !== 1'b0) @(negedge ref_clk_in);
        while (bclk_out !== 1'b1) @(negedge ref_clk_in);
        while (bclk_out === 1'b1 && c < 300) begin
            c++;
            @(negedge ref_clk_in);
        end
    endtask : half_len

    logic [7:0] mode_tbl [4] = '{8'h00, 8'h20, 8'h40, 8'h87};
    // {bit clock oe_n, frame sync oe_n, pll, custom}
    logic [3:0] mode_exp [4] = '{4'b1110, 4'b1100, 4'b1101, 4'b0010};
    int sl_ns [3] = '{20833, 22676, 20833};
    int sl_rat [3] = '{128, 64, 100};
    logic [7:0] sl_exp [3] = '{8'h46, 8'h44, 8'h4F};

    initial begin
        repeat (12) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        @(negedge ref_clk_in);
        `CHK("pll", 1'b1, pll_run_out)
        `CHK("custom", 1'b0, custom_clk_out)
        `CHK("code", 3'h2, master_clock_freq_code_out)
        `CHK("oe_n", 1'b1, bclk_oe_n_out)
        rdreg(MODE_CFG_OFS, rd); `CHK("mode", 8'h02, rd)
        rdreg(RATE_CFG_OFS, rd); `CHK("rate", 8'h48, rd)
        rdreg(MON_STS_OFS, rd); `CHK("sts", 8'hFF, rd)
        rdreg(8'h20, rd); `CHK("unmapped", 8'h00, rd)
        wr(MON_STS_OFS, 8'h00); rdreg(MON_STS_OFS, rd); `CHK("sts ro", 8'hFF, rd)
        wr(RATE_CFG_OFS, 8'h5A); rdreg(RATE_CFG_OFS, rd); `CHK("rate rw", 8'h5A, rd)
        wr(CLK_SRC_OFS, 8'hFF); rdreg(CLK_SRC_OFS, rd); `CHK("style", 8'h40, rd)
        `CHK("mclk src", 1'b0, mclk_from_code_out)
        wr(CLK_SRC_OFS, 8'h00);
        `CHK("mclk code", 1'b1, mclk_from_code_out)
        foreach (mode_tbl[k]) begin
            wr(MODE_CFG_OFS, mode_tbl[k]);
            n = {28'h0, bclk_oe_n_out, frame_sync_oe_n_out, pll_run_out, custom_clk_out};
            `CHK("mode out", mode_exp[k], n[3:0])
        end
        `CHK("code", 3'h7, master_clock_freq_code_out)
        wr(RATE_CFG_OFS, 8'h48);
        count_rises(n); `CHK("bclk runs", 1'b1, n > 0)
        wr(MODE_CFG_OFS, 8'h97);
        count_rises(n); `CHK("gated", 0, n)
        `CHK("fs gated", 1'b0, frame_sync_out)
        wr(MODE_CFG_OFS, 8'h80);
        wr(RATE_CFG_OFS, 8'h24);
        // half period from the 48 kHz table: 24 kHz, 64 bits per frame
        half_len(n); `CHK("half 48k", CLK_HZ / (2 * RATE48_HZ[2] * RATIO_TBL[4]), n)
        wait_sts(8'h24, 3000); `CHK("mst sts", 8'h24, rd)
        wr(MODE_CFG_OFS, 8'h88);
        // status codes hide the family, so the divider itself must move: 14.7 kHz, 16 bits
        wr(RATE_CFG_OFS, 8'h10);
        half_len(n); `CHK("half 44k", CLK_HZ / (2 * RATE44_HZ[1] * RATIO_TBL[0]), n)
        wr(RATE_CFG_OFS, 8'h48);
        wait_sts(8'h48, 3000); `CHK("family", 8'h48, rd)
        // slave: host drives the bus, status follows each frame pattern
        wr(MODE_CFG_OFS, 8'h00);
        foreach (sl_ns[k]) begin
            host_frame_ns = sl_ns[k];
            host_ratio = sl_rat[k][11:0];
            host_run = 1'b1;
            wait_sts(sl_exp[k], 4000); `CHK("slave sts", sl_exp[k], rd)
        end
        host_run = 1'b0;
        wait_sts(8'hFF, 6000); `CHK("timeout", 8'hFF, rd)
        finish_test();
    end
endmodule : apc_top_tb
